// *** cmc_pkg.sv ***
package cmc_pkg;
    // operating states
    typedef enum logic [2:0] {
        CMC_SLEEP  = 3'b000,
        CMC_INIT   = 3'b001,
        CMC_SYNC   = 3'b010,
        CMC_NORMAL = 3'b011,
        CMC_WAKE   = 3'b100
    } cmc_state_t;

    // bus levels
    localparam logic       CMC_RECESSIVE = 1'b1;
    localparam logic       CMC_DOMINANT  = 1'b0;
    // recessive bits that make bus idle
    localparam logic [3:0] CMC_IDLE_BITS = 4'hB;
    localparam logic [3:0] CMC_CNT_ONE   = 4'h1;
    // identifier widths
    localparam int         CMC_ID_W      = 29;
    localparam int         CMC_STD_W     = 11;
    localparam int         CMC_EXT_PAD   = CMC_ID_W - CMC_STD_W;
    // receive message slots
    localparam logic [1:0] CMC_MSG_MAX   = 2'h3;
    localparam logic [1:0] CMC_MSG_ONE   = 2'h1;
    // paged window: 16-byte pages
    localparam int         CMC_OFFS_W    = 4;
    localparam int         CMC_PAGE_W    = 3;
    // receive data buffer
    localparam int         CMC_FIFO_W    = 8;
    localparam int         CMC_FIFO_D    = 8;
endpackage : cmc_pkg

// *** cmc_mode_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none

module cmc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_ce,
    // fill side
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output logic              o_ready,
    // drain side
    output logic              o_valid,
    output logic [W-1:0]      o_data,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH = (AW+1)'(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    wire           push = i_ce && i_valid && o_ready;
    wire           pop  = i_ce && o_valid && i_ready;
    wire [AW-1:0]  wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    wire [AW-1:0]  rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    // a push into the slot about to be shown goes straight out
    wire           bypass = push && (wr_q == rd_d);

    assign cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            o_ready <= 1'b1;
            o_valid <= 1'b0;
            o_data  <= '0;
        end else if (i_ce) begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            cnt_q   <= cnt_d;
            o_ready <= (cnt_d != DEPTH);
            o_valid <= (cnt_d != '0);
            o_data  <= bypass ? i_data : mem_q[rd_d];
        end
    end
endmodule // cmc_fifo

module cmc_mode_ctrl
    import cmc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_clk_en,
    // control bits
    input  wire logic                  i_init_request,
    input  wire logic                  i_sleep_request,
    input  wire logic                  i_auto_wakeup_select,
    input  wire logic                  i_wakeup_irq_enable,
    input  wire logic                  i_silent_select,
    input  wire logic                  i_loopback_select,
    // status bits
    output logic                       o_init_acknowledge,
    output logic                       o_sleep_acknowledge,
    output logic                       o_normal_mode,
    output logic                       o_sleep_request_clr,
    output logic                       o_wakeup_irq,
    // bus pins
    input  wire logic                  i_bus_rx_pin,
    output logic                       o_bus_tx_pin,
    // protocol core side
    input  wire logic                  i_bit_tick,
    input  wire logic                  i_core_tx,
    output logic                       o_core_rx,
    output logic                       o_core_clk_en,
    output logic                       o_tx_allow,
    output logic                       o_ack_err_ignore,
    // transmit mailboxes
    input  wire logic [1:0]            i_tx_pending,
    input  wire logic [1:0]            i_tx_ext,
    input  wire logic [CMC_ID_W-1:0]   i_tx_id0,
    input  wire logic [CMC_ID_W-1:0]   i_tx_id1,
    output logic                       o_tx_sel,
    output logic                       o_tx_go,
    // receive message store
    input  wire logic                  i_msg_stored,
    input  wire logic                  i_msg_release,
    input  wire logic                  i_overrun_clr,
    output logic [1:0]                 o_msg_count,
    output logic                       o_msg_overrun,
    // receive data stream
    input  wire logic                  i_rx_valid,
    input  wire logic [CMC_FIFO_W-1:0] i_rx_data,
    output logic                       o_rx_ready,
    output logic                       o_rd_valid,
    output logic [CMC_FIFO_W-1:0]      o_rd_data,
    input  wire logic                  i_rd_ready,
    // paged window
    input  wire logic [CMC_PAGE_W-1:0] i_page_sel,
    input  wire logic [CMC_OFFS_W-1:0] i_win_offs,
    output logic [CMC_PAGE_W+CMC_OFFS_W-1:0] o_win_addr
);
    cmc_state_t state_q;
    cmc_state_t state_d;
    logic       rx_meta_q;
    logic       rx_sync_q;
    logic       rx_prev_q;
    logic [3:0] idle_cnt_q;
    logic       silent_q;
    logic       lbk_q;
    logic [1:0] msg_q;

    // receive level seen by the core path
    wire rx_eff = lbk_q ? i_core_tx :
                  (silent_q ? (rx_sync_q & i_core_tx) : rx_sync_q);
    wire syncing = (state_q == CMC_SYNC) || (state_q == CMC_WAKE);
    wire bus_idle = (idle_cnt_q == CMC_IDLE_BITS);
    wire activity = (state_q == CMC_SLEEP) &&
                    (rx_sync_q == CMC_DOMINANT);
    wire act_edge = activity && (rx_prev_q == CMC_RECESSIVE);
    wire auto_wake = activity && i_auto_wakeup_select;
    wire run_d = (state_d == CMC_NORMAL);
    wire tx_ok_d = run_d && !silent_q;
    wire awake = (state_q != CMC_SLEEP);

    // identifier keys: standard ids align with extended msbs
    wire [CMC_ID_W-1:0] key0 = i_tx_ext[0] ? i_tx_id0 :
        {i_tx_id0[CMC_STD_W-1:0], {CMC_EXT_PAD{1'b0}}};
    wire [CMC_ID_W-1:0] key1 = i_tx_ext[1] ? i_tx_id1 :
        {i_tx_id1[CMC_STD_W-1:0], {CMC_EXT_PAD{1'b0}}};
    wire pick1 = i_tx_pending[1] &&
                 (!i_tx_pending[0] || (key1 < key0));

    // message store counter next values
    wire msg_dec = i_msg_release && (msg_q != '0);
    wire msg_inc = i_msg_stored && (msg_q != CMC_MSG_MAX || msg_dec);
    wire msg_ovf = i_msg_stored && (msg_q == CMC_MSG_MAX) &&
                   !msg_dec;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CMC_SLEEP: begin
                // init request ignored here
                if (!i_sleep_request || auto_wake) begin
                    state_d = CMC_WAKE;
                end
            end
            CMC_WAKE: begin
                // request bit still set while its clear is under way
                if (i_sleep_request && !o_sleep_request_clr) begin
                    state_d = CMC_SLEEP;
                end else if (bus_idle) begin
                    state_d = CMC_NORMAL;
                end
            end
            CMC_INIT: begin
                if (!i_init_request) begin
                    state_d = i_sleep_request ? CMC_SLEEP
                                              : CMC_SYNC;
                end
            end
            CMC_SYNC: begin
                if (i_init_request) begin
                    state_d = CMC_INIT;
                end else if (i_sleep_request) begin
                    state_d = CMC_SLEEP;
                end else if (bus_idle) begin
                    state_d = CMC_NORMAL;
                end
            end
            CMC_NORMAL: begin
                if (i_init_request) begin
                    state_d = CMC_INIT;
                end else if (i_sleep_request) begin
                    state_d = CMC_SLEEP;
                end
            end
            default: begin
                state_d = CMC_SLEEP;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_q <= CMC_SLEEP;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

    // two-stage receive pin synchroniser
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            rx_meta_q <= CMC_RECESSIVE;
            rx_sync_q <= CMC_RECESSIVE;
            rx_prev_q <= CMC_RECESSIVE;
        end else if (i_clk_en) begin
            rx_meta_q <= i_bus_rx_pin;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // consecutive recessive bit counter
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            idle_cnt_q <= '0;
        end else if (i_clk_en) begin
            if (!syncing || state_d != state_q) begin
                idle_cnt_q <= '0;
            end else if (i_bit_tick && !bus_idle) begin
                idle_cnt_q <= (rx_eff == CMC_RECESSIVE) ?
                    idle_cnt_q + CMC_CNT_ONE : '0;
            end
        end
    end

    // test selection caught in init; other config untouched
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            silent_q <= 1'b0;
            lbk_q    <= 1'b0;
        end else if (i_clk_en && state_q == CMC_INIT) begin
            silent_q <= i_silent_select;
            lbk_q    <= i_loopback_select;
        end
    end

    // mode status and pin outputs
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_init_acknowledge  <= 1'b0;
            o_sleep_acknowledge <= 1'b1;
            o_normal_mode       <= 1'b0;
            o_sleep_request_clr <= 1'b0;
            o_wakeup_irq        <= 1'b0;
            o_bus_tx_pin        <= CMC_RECESSIVE;
            o_core_rx           <= CMC_RECESSIVE;
            o_core_clk_en       <= 1'b0;
            o_tx_allow          <= 1'b0;
            o_ack_err_ignore    <= 1'b0;
        end else if (i_clk_en) begin
            o_init_acknowledge  <= (state_d == CMC_INIT);
            o_sleep_acknowledge <= (state_d == CMC_SLEEP) ||
                                   (state_d == CMC_WAKE);
            o_normal_mode       <= run_d || (state_d == CMC_SYNC);
            o_sleep_request_clr <= auto_wake;
            o_wakeup_irq        <= act_edge &&
                                   i_wakeup_irq_enable;
            o_bus_tx_pin        <= tx_ok_d ? i_core_tx
                                           : CMC_RECESSIVE;
            o_core_rx           <= rx_eff;
            o_core_clk_en       <= (state_d != CMC_SLEEP);
            o_tx_allow          <= tx_ok_d;
            o_ack_err_ignore    <= lbk_q;
        end
    end

    // scheduler and window address
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_tx_sel   <= 1'b0;
            o_tx_go    <= 1'b0;
            o_win_addr <= '0;
        end else if (i_clk_en) begin
            o_tx_sel   <= pick1;
            o_tx_go    <= tx_ok_d && (i_tx_pending != '0);
            o_win_addr <= {i_page_sel, i_win_offs};
        end
    end

    // message store status, frozen in sleep
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            msg_q         <= '0;
            o_msg_overrun <= 1'b0;
        end else if (i_clk_en && awake) begin
            msg_q <= msg_q + (msg_inc ? CMC_MSG_ONE : '0)
                           - (msg_dec ? CMC_MSG_ONE : '0);
            o_msg_overrun <= msg_ovf ||
                             (o_msg_overrun && !i_overrun_clr);
        end
    end
    assign o_msg_count = msg_q;

    cmc_fifo #(
        .W (CMC_FIFO_W),
        .D (CMC_FIFO_D)
    ) u_rx_fifo (
        .i_clk   (i_sys_clk),
        .i_rstn  (i_rstn),
        .i_ce    (i_clk_en),
        .i_valid (i_rx_valid && awake),
        .i_data  (i_rx_data),
        .o_ready (o_rx_ready),
        .o_valid (o_rd_valid),
        .o_data  (o_rd_data),
        .i_ready (i_rd_ready)
    );

    sequence seq_wake_edge;
        i_clk_en && act_edge && i_wakeup_irq_enable;
    endsequence

    sequence seq_auto_wake;
        i_clk_en && auto_wake;
    endsequence

    AST_RESET_SLEEP: assert property (@(posedge i_sys_clk)
        !$past(i_rstn) && i_rstn |-> state_q == CMC_SLEEP
            && o_sleep_acknowledge)
        else $error("not asleep after reset");
    AST_NORMAL_IFF: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        o_normal_mode == (!o_init_acknowledge && !o_sleep_acknowledge))
        else $error("normal flag disagrees with acks");
    AST_INIT_TX: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        o_init_acknowledge |-> o_bus_tx_pin && !o_tx_allow)
        else $error("transmit active in init");
    AST_SLEEP_NO_INIT: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        state_q == CMC_SLEEP && i_clk_en |=> !o_init_acknowledge)
        else $error("init acknowledged from sleep");
    AST_WAKE_IRQ: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        seq_wake_edge |=> o_wakeup_irq)
        else $error("wake-up interrupt missing");
    AST_AUTO_CLR: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        seq_auto_wake |=> o_sleep_request_clr && state_q == CMC_WAKE)
        else $error("auto wake-up did not clear request");
    AST_SILENT_TX: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        silent_q && $past(silent_q) |-> o_bus_tx_pin && !o_tx_go)
        else $error("silent mode drove the bus");
    AST_IDLE_WAIT: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        $rose(o_tx_allow) |-> $past(idle_cnt_q) == CMC_IDLE_BITS)
        else $error("normal entered before bus idle");
    AST_LOOPBACK_RX: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        i_clk_en && lbk_q |=> o_core_rx == $past(i_core_tx))
        else $error("loopback receive not internal");
    AST_SLEEP_EXIT: assert property (@(posedge i_sys_clk)
        disable iff (!i_rstn)
        $fell(o_sleep_acknowledge) |-> $past(state_q) == CMC_WAKE
            && $past(bus_idle))
        else $error("sleep left without bus sync");
endmodule // cmc_mode_ctrl
`default_nettype wire

// *** cmc_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cmc_bus_model #(
    parameter int BIT_CYC = 4
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // bus side
    input  wire logic i_tx,
    input  wire logic i_dom,
    output logic      o_rx,
    output logic      o_tick
);
    logic [7:0] cnt_q;
    // wired-and bus, pulled recessive when nobody drives
    assign o_rx   = i_tx & ~i_dom;
    // sample point once per bit time
    assign o_tick = (cnt_q == 8'h0);
    always_ff @(posedge i_clk) begin
        if (!i_rstn || o_tick) begin
            cnt_q <= 8'(BIT_CYC - 1);
        end else begin
            cnt_q <= cnt_q - 8'h1;
        end
    end
endmodule // cmc_bus_model
`default_nettype wire

// *** cmc_mode_ctrl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module cmc_mode_ctrl_tb;
    import cmc_pkg::*;
    logic clk = 0, rstn = 0, clk_en = 1, init_req = 0, sleep_req = 1;
    logic awu = 1, wie = 1, sil = 0, lbk = 0, dom = 0, core_tx = 1;
    logic msg_st = 0, msg_rel = 0, ovr_clr = 0, rx_valid = 0, rd_ready = 0;
    logic [1:0] tx_pend = 2'h0, tx_ext = 2'h0;
    logic [CMC_ID_W-1:0] id0 = '0, id1 = '0;
    logic [7:0] rx_data = 8'h00;
    logic [2:0] page = 3'h5;
    logic [3:0] offs = 4'hA;
    logic init_ack, sleep_ack, normal, slp_clr, wk_irq, rx, tx_pin, tick;
    logic core_rx, core_clk_en, tx_allow, ack_ign, tx_sel, tx_go, ovr;
    logic rx_ready, rd_valid;
    logic [1:0] msg_cnt;
    logic [7:0] rd_data;
    logic [6:0] win_addr;
    int n_mismatch = 0, total_checks = 0, n, i;
    logic seen_irq, seen_clr, acc;

    initial begin
        forever #10 clk = ~clk;
    end

    cmc_bus_model #(.BIT_CYC(4)) u_bus (.i_clk(clk), .i_rstn(rstn),
        .i_tx(tx_pin), .i_dom(dom), .o_rx(rx), .o_tick(tick));

    cmc_mode_ctrl u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(clk_en),
        .i_init_request(init_req), .i_sleep_request(sleep_req),
        .i_auto_wakeup_select(awu), .i_wakeup_irq_enable(wie),
        .i_silent_select(sil), .i_loopback_select(lbk),
        .o_init_acknowledge(init_ack), .o_sleep_acknowledge(sleep_ack),
        .o_normal_mode(normal), .o_sleep_request_clr(slp_clr),
        .o_wakeup_irq(wk_irq), .i_bus_rx_pin(rx), .o_bus_tx_pin(tx_pin),
        .i_bit_tick(tick), .i_core_tx(core_tx), .o_core_rx(core_rx),
        .o_core_clk_en(core_clk_en), .o_tx_allow(tx_allow),
        .o_ack_err_ignore(ack_ign), .i_tx_pending(tx_pend),
        .i_tx_ext(tx_ext), .i_tx_id0(id0), .i_tx_id1(id1),
        .o_tx_sel(tx_sel), .o_tx_go(tx_go), .i_msg_stored(msg_st),
        .i_msg_release(msg_rel), .i_overrun_clr(ovr_clr),
        .o_msg_count(msg_cnt), .o_msg_overrun(ovr), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .i_rd_ready(rd_ready), .i_page_sel(page),
        .i_win_offs(offs), .o_win_addr(win_addr));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // wait for ack pair, return in n the edges seen before the matching one
    task automatic wait_mode(input logic ia, input logic sa);
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            #1;
            if (init_ack === ia && sleep_ack === sa) break;
        end
        `CHK("ack pair", {ia, sa}, {init_ack, sleep_ack})
    endtask

    // watch wake-up pulses for a few cycles
    task automatic watch_wake;
        seen_irq = 0;
        seen_clr = 0;
        repeat (12) begin
            @(posedge clk);
            // request bit clears one edge after the pulse
            if (seen_clr) sleep_req <= 1'b0;
            #1;
            if (wk_irq === 1'b1) seen_irq = 1;
            if (slp_clr === 1'b1) seen_clr = 1;
        end
    endtask

    // let sync finish, then put a core bit out
    task automatic settle(input int cyc, input logic c);
        repeat (cyc) @(posedge clk);
        core_tx <= c;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic enter_init;
        @(posedge clk);
        init_req <= 1'b1;
        wait_mode(1'b1, 1'b0);
    endtask

    task automatic leave_init;
        @(posedge clk);
        init_req <= 1'b0;
        wait_mode(1'b0, 1'b0);
    endtask

    task automatic sched(input logic [28:0] a, input logic [28:0] b,
                         input logic [1:0] p, input logic [1:0] x,
                         input logic e);
        @(posedge clk);
        id0 <= a;
        id1 <= b;
        tx_pend <= p;
        tx_ext <= x;
        repeat (3) @(posedge clk);
        #1;
        `CHK("tx_sel", e, tx_sel)
        `CHK("tx_go", 1'b1, tx_go)
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        `CHK("reset acks", 3'b010, {init_ack, sleep_ack, normal})
        `CHK("reset tx", 1'b1, tx_pin)
        `CHK("sleep clk", 1'b0, core_clk_en)
        @(posedge clk);
        init_req <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK("init in sleep", 1'b0, init_ack)
        @(posedge clk);
        init_req <= 1'b0;
        dom <= 1'b1;
        watch_wake();
        `CHK("wake irq", 1'b1, seen_irq)
        `CHK("auto clr", 1'b1, seen_clr)
        @(posedge clk);
        dom <= 1'b0;
        sleep_req <= 1'b0;
        wait_mode(1'b0, 1'b0);
        `CHK("idle wait", 1'b1, n >= 40)
        `CHK("normal", 1'b1, normal)
        `CHK("run clk", 1'b1, core_clk_en)
        core_tx <= 1'b0;
        tx_pend <= 2'h3;
        enter_init();
        `CHK("init tx pin", 1'b1, tx_pin)
        `CHK("init no go", 1'b0, tx_go)
        `CHK("init normal", 1'b0, normal)
        `CHK("window", 7'h5A, win_addr)
        sil <= 1'b1;
        core_tx <= 1'b1;
        leave_init();
        `CHK("sync normal", 1'b1, normal)
        settle(60, 1'b0);
        `CHK("silent allow", 1'b0, tx_allow)
        `CHK("silent go", 1'b0, tx_go)
        `CHK("silent pin", 1'b1, tx_pin)
        `CHK("silent fb", 1'b0, core_rx)
        enter_init();
        lbk <= 1'b1;
        dom <= 1'b1;
        core_tx <= 1'b1;
        leave_init();
        settle(60, 1'b1);
        `CHK("lb ack ign", 1'b1, ack_ign)
        `CHK("lb rx cut", 1'b1, core_rx)
        settle(0, 1'b0);
        `CHK("lb pin", 1'b1, tx_pin)
        `CHK("lb fb", 1'b0, core_rx)
        enter_init();
        sil <= 1'b0;
        core_tx <= 1'b1;
        leave_init();
        settle(60, 1'b0);
        `CHK("lb out pin", 1'b0, tx_pin)
        enter_init();
        lbk <= 1'b0;
        dom <= 1'b0;
        leave_init();
        settle(60, 1'b0);
        `CHK("plain allow", 1'b1, tx_allow)
        `CHK("plain pin", 1'b0, tx_pin)
        sched(29'h123, 29'h045, 2'h3, 2'h0, 1'b1);
        sched(29'h045, 29'h045, 2'h3, 2'h0, 1'b0);
        sched(29'h045, 29'h123, 2'h2, 2'h0, 1'b1);
        sched(29'h10000000, 29'h0FFFFFFF, 2'h3, 2'h3, 1'b1);
        sched(29'h400, 29'h0FFFFFFF, 2'h3, 2'h2, 1'b1);
        repeat (4) begin
            @(posedge clk);
            msg_st <= 1'b1;
            @(posedge clk);
            msg_st <= 1'b0;
        end
        @(posedge clk);
        #1;
        `CHK("msg full", 3'h7, {msg_cnt, ovr})
        msg_rel <= 1'b1;
        ovr_clr <= 1'b1;
        @(posedge clk);
        msg_rel <= 1'b0;
        ovr_clr <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("msg rel", 3'h4, {msg_cnt, ovr})
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= 8'hA0;
        n = 0;
        for (i = 0; i < 12; i++) begin
            #1 acc = rx_ready;
            @(posedge clk);
            if (acc) n++;
            rx_data <= 8'hA0 + 8'(n);
        end
        rx_valid <= 1'b0;
        #1;
        `CHK("fifo fill", 9'h010, {n[7:0], rx_ready})
        @(posedge clk);
        rd_ready <= 1'b1;
        for (i = 0; i < 8; i++) begin
            #1;
            `CHK("fifo data", 9'h1A0 + 9'(i), {rd_valid, rd_data})
            @(posedge clk);
        end
        #1;
        `CHK("fifo empty", 1'b0, rd_valid)
        core_tx <= 1'b1;
        awu <= 1'b0;
        wie <= 1'b0;
        sleep_req <= 1'b1;
        wait_mode(1'b0, 1'b1);
        `CHK("sleep clk off", 1'b0, core_clk_en)
        @(posedge clk);
        msg_st <= 1'b1;
        @(posedge clk);
        msg_st <= 1'b0;
        dom <= 1'b1;
        watch_wake();
        `CHK("no irq", 2'b00, {seen_irq, seen_clr})
        `CHK("sleep frozen", 2'h2, msg_cnt)
        @(posedge clk);
        dom <= 1'b0;
        sleep_req <= 1'b0;
        wait_mode(1'b0, 1'b0);
        give_verdict();
    end
endmodule // cmc_mode_ctrl_tb
`default_nettype wire
